// [design/sles_pkg.sv]
// Register map, field positions, reset values and boost code constants for the strobe event block.
package sles_pkg;
	// Register offsets.
	localparam logic [7:0] SLES_ADDR_BOOST_MODE = 8'h0A;
	localparam logic [7:0] SLES_ADDR_BOOST_CODE = 8'h0B;
	localparam logic [7:0] SLES_ADDR_EVENTS = 8'h0E;
	localparam logic [7:0] SLES_ADDR_MASKS = 8'h0F;
	localparam logic [7:0] SLES_ADDR_ACTIVITY = 8'h10;

	// Reset values.
	localparam logic [7:0] SLES_EVENTS_RST = 8'h00;
	localparam logic [7:0] SLES_MASKS_RST = 8'hFF;
	localparam logic [7:0] SLES_ACTIVITY_RST = 8'h00;
	localparam logic [2:0] SLES_MODE_RST = 3'h0;
	localparam logic [6:0] SLES_CODE_RST = 7'h00;

	// Event and mask bit positions.
	localparam int SLES_BIT_B_OPEN = 0;
	localparam int SLES_BIT_B_SHORT = 1;
	localparam int SLES_BIT_A_OPEN = 2;
	localparam int SLES_BIT_A_SHORT = 3;
	localparam int SLES_BIT_REDUCTION = 4;
	localparam int SLES_BIT_NOT_HELD = 5;
	localparam int SLES_NUM_EVENTS = 6;

	// Activity status bit positions.
	localparam int SLES_BIT_TORCH_ON = 2;
	localparam int SLES_BIT_STROBE_ON = 3;

	// Boost operating mode encodings.
	localparam logic [2:0] SLES_MODE_OFF = 3'h0;
	localparam logic [2:0] SLES_MODE_ADAPT_A = 3'h1;
	localparam logic [2:0] SLES_MODE_ADAPT_B = 3'h2;
	localparam logic [2:0] SLES_MODE_ADAPT_AB = 3'h3;
	localparam logic [2:0] SLES_MODE_FIXED = 3'h4;

	// Boost output voltage decoding, in millivolts.
	localparam logic [6:0] SLES_CODE_FLOOR = 7'h0C;
	localparam logic [6:0] SLES_CODE_CEIL = 7'h64;
	localparam logic [12:0] SLES_MV_MIN = 13'h0CE4;
	localparam logic [12:0] SLES_MV_MAX = 13'h157C;
	localparam logic [12:0] SLES_MV_STEP = 13'h0019;
endpackage : sles_pkg

// [design/sles_regs.sv]
// Event, mask and activity registers of the strobe LED driver with boost code decoding.
//
// Contract
// - Decode boost code: floor 3.3V, 25mV steps, 5.5V cap.
// - Event register resets zero, clears on read.
// - Bit 0 flags channel B open.
// - Bit 1 flags channel B short.
// - Bit 2 flags channel A open.
// - Bit 3 flags channel A short.
// - Bit 4 flags current reduction during strobe.
// - Bit 5 flags LED current not held.
// - Masks reset ones; bits 0-3 one masks.
// - Mask bit 4: one unmasks, zero masks.
// - Mask bit 5: one unmasks, zero masks.
// - Activity bit 2 shows torch in progress.
// - Activity bit 3 shows strobe; others zero.
// - Adaptive modes ignore the boost voltage code.
// - Mode field: off, adaptive A/B/both, fixed.
`timescale 1ns/1ns
module sles_regs (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Register access from the serial interface engine.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Fault detectors, one-cycle or level, active high.
	input wire logic chan_b_open_evt,
	input wire logic chan_b_short_evt,
	input wire logic chan_a_open_evt,
	input wire logic chan_a_short_evt,
	input wire logic current_reduction_irq,
	input wire logic current_not_held_evt,
	// Activity from the LED sequencer.
	input wire logic torch_active,
	input wire logic strobe_active,
	// Boost converter control.
	output logic [2:0] boost_mode,
	output logic boost_use_adaptive,
	output logic boost_fixed,
	output logic [12:0] boost_target_mv,
	// Combined interrupt request, active high.
	output logic event_irq
);
	typedef struct packed {
		logic [5:0] events;
		logic [7:0] masks;
		logic [2:0] mode;
		logic [6:0] code;
		logic [7:0] rdata;
		logic rvalid;
		logic irq;
		logic [12:0] target_mv;
	} sles_state_t;

	sles_state_t st;
	sles_state_t next_st;
	logic [5:0] evt_in;
	logic [5:0] unmasked;
	logic [7:0] activity;
	logic [7:0] decode_tmp;

	// Only channel detectors feed bits 0 to 3; the order follows the register layout.
	always_comb
	begin
		evt_in = '0;
		evt_in[sles_pkg::SLES_BIT_B_OPEN] = chan_b_open_evt;
		evt_in[sles_pkg::SLES_BIT_B_SHORT] = chan_b_short_evt;
		evt_in[sles_pkg::SLES_BIT_A_OPEN] = chan_a_open_evt;
		evt_in[sles_pkg::SLES_BIT_A_SHORT] = chan_a_short_evt;
		evt_in[sles_pkg::SLES_BIT_REDUCTION] = current_reduction_irq;
		evt_in[sles_pkg::SLES_BIT_NOT_HELD] = current_not_held_evt;
	end

	// Bits 4 and 5 keep their inverted sense, so the 0xFF reset leaves them unmasked.
	always_comb
	begin
		unmasked[3:0] = st.events[3:0] & ~st.masks[3:0];
		unmasked[4] = st.events[4] & st.masks[4];
		unmasked[5] = st.events[5] & st.masks[5];
	end

	always_comb
	begin
		activity = sles_pkg::SLES_ACTIVITY_RST;
		activity[sles_pkg::SLES_BIT_TORCH_ON] = torch_active;
		activity[sles_pkg::SLES_BIT_STROBE_ON] = strobe_active;
	end

	always_comb
	begin
		decode_tmp = 8'h00;
		next_st = st;
		next_st.rvalid = reg_rd;
		if (reg_rd)
		begin
			unique case (reg_addr)
				sles_pkg::SLES_ADDR_BOOST_MODE: next_st.rdata = {5'h00, st.mode};
				sles_pkg::SLES_ADDR_BOOST_CODE: next_st.rdata = {1'b0, st.code};
				sles_pkg::SLES_ADDR_EVENTS: next_st.rdata = {2'h0, st.events};
				sles_pkg::SLES_ADDR_MASKS: next_st.rdata = st.masks;
				sles_pkg::SLES_ADDR_ACTIVITY: next_st.rdata = activity;
				default: next_st.rdata = 8'h00;
			endcase
		end
		// A write and a read in one cycle are both honoured; writes to read-only space drop.
		if (reg_wr)
		begin
			unique case (reg_addr)
				sles_pkg::SLES_ADDR_BOOST_MODE: next_st.mode = reg_wdata[2:0];
				sles_pkg::SLES_ADDR_BOOST_CODE: next_st.code = reg_wdata[6:0];
				sles_pkg::SLES_ADDR_MASKS: next_st.masks = reg_wdata;
				default: next_st.mode = st.mode;
			endcase
		end
		// Clear first, then set, so a detector firing during the read is kept.
		if (reg_rd && reg_addr == sles_pkg::SLES_ADDR_EVENTS)
			next_st.events = '0;
		next_st.events = next_st.events | evt_in;
		next_st.irq = |unmasked;
		if (st.code <= sles_pkg::SLES_CODE_FLOOR)
			next_st.target_mv = sles_pkg::SLES_MV_MIN;
		else if (st.code >= sles_pkg::SLES_CODE_CEIL)
			next_st.target_mv = sles_pkg::SLES_MV_MAX;
		else
		begin
			decode_tmp = {1'b0, st.code - sles_pkg::SLES_CODE_FLOOR};
			next_st.target_mv = 13'(sles_pkg::SLES_MV_MIN
				+ sles_pkg::SLES_MV_STEP * {5'h00, decode_tmp});
		end
		// The code has no effect unless the converter runs at a fixed target.
		if (st.mode != sles_pkg::SLES_MODE_FIXED)
			next_st.target_mv = 13'h0000;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st.events <= sles_pkg::SLES_EVENTS_RST[5:0];
			st.masks <= sles_pkg::SLES_MASKS_RST;
			st.mode <= sles_pkg::SLES_MODE_RST;
			st.code <= sles_pkg::SLES_CODE_RST;
			st.rdata <= 8'h00;
			st.rvalid <= 1'b0;
			st.irq <= 1'b0;
			st.target_mv <= 13'h0000;
		end
		else
			st <= next_st;
	end

	// Reserved mode codes behave as off.
	always_comb
	begin
		boost_use_adaptive = 1'b0;
		boost_fixed = 1'b0;
		unique case (st.mode)
			sles_pkg::SLES_MODE_ADAPT_A,
			sles_pkg::SLES_MODE_ADAPT_B,
			sles_pkg::SLES_MODE_ADAPT_AB: boost_use_adaptive = 1'b1;
			sles_pkg::SLES_MODE_FIXED: boost_fixed = 1'b1;
			default: boost_fixed = 1'b0;
		endcase
	end

	assign boost_mode = st.mode;
	assign boost_target_mv = st.target_mv;
	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;
	assign event_irq = st.irq;

	logic rd_events;
	assign rd_events = reg_rd && reg_addr == sles_pkg::SLES_ADDR_EVENTS;

	property p_code_floor;
		@(posedge clk) disable iff (!resetn)
		(st.mode == sles_pkg::SLES_MODE_FIXED && st.code <= 7'h0C) |=> boost_target_mv == 13'h0CE4;
	endproperty
	a_code_floor: assert property (p_code_floor) else $error("Low code not at 3300 mV.");

	property p_code_ceil;
		@(posedge clk) disable iff (!resetn)
		(st.mode == sles_pkg::SLES_MODE_FIXED && st.code >= 7'h64) |=> boost_target_mv == 13'h157C;
	endproperty
	a_code_ceil: assert property (p_code_ceil) else $error("High code not at 5500 mV.");

	property p_code_step;
		@(posedge clk) disable iff (!resetn)
		(st.mode == sles_pkg::SLES_MODE_FIXED && st.code > 7'h0C && st.code < 7'h64)
		|=> int'(boost_target_mv) == 3300 + 25 * (int'($past(st.code)) - 12);
	endproperty
	a_code_step: assert property (p_code_step) else $error("Step code decoded wrongly.");

	property p_adaptive_ignores;
		@(posedge clk) disable iff (!resetn)
		(boost_use_adaptive ##1 boost_use_adaptive) |-> boost_target_mv == 13'h0000 && !boost_fixed;
	endproperty
	a_adaptive_ignores: assert property (p_adaptive_ignores) else $error("Adaptive used code.");

	property p_read_clears;
		@(posedge clk) disable iff (!resetn)
		(rd_events && evt_in == 6'h00) |=> st.events == 6'h00 && reg_rdata == {2'h0, $past(st.events)};
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("Event read did not clear.");

	property p_event_kept;
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> (st.events & $past(evt_in)) == $past(evt_in);
	endproperty
	a_event_kept: assert property (p_event_kept) else $error("Event was lost.");

	property p_sticky;
		@(posedge clk) disable iff (!resetn)
		!rd_events |=> (st.events & $past(st.events)) == $past(st.events);
	endproperty
	a_sticky: assert property (p_sticky) else $error("Event dropped without read.");

	property p_reset_values;
		@(posedge clk)
		!resetn |=> st.masks == 8'hFF && st.events == 6'h00 && !event_irq;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("Wrong reset values.");

	property p_irq;
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> event_irq == ((|($past(st.events[3:0]) & ~$past(st.masks[3:0])))
			|| (|($past(st.events[5:4]) & $past(st.masks[5:4]))));
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt request wrong.");

	property p_activity;
		@(posedge clk) disable iff (!resetn)
		(reg_rd && reg_addr == sles_pkg::SLES_ADDR_ACTIVITY)
		|=> reg_rvalid && reg_rdata == {4'h0, $past(strobe_active), $past(torch_active), 2'h0};
	endproperty
	a_activity: assert property (p_activity) else $error("Activity read wrong.");

	c_read_collision: cover property (@(posedge clk) disable iff (!resetn)
		rd_events && evt_in != 6'h00 ##1 st.events != 6'h00);
	c_irq_rise: cover property (@(posedge clk) disable iff (!resetn) $rose(event_irq));
	c_saturated: cover property (@(posedge clk) disable iff (!resetn)
		boost_fixed && boost_target_mv == 13'h157C);
	c_mask_write: cover property (@(posedge clk) disable iff (!resetn)
		reg_wr && reg_addr == sles_pkg::SLES_ADDR_MASKS ##1 st.masks == 8'h00);
endmodule : sles_regs

// [tb/sles_far_side.sv]
// Behavioural model of the fault detectors and the LED sequencer.
`timescale 1ns/1ns
module sles_far_side (
	// Clock.
	input wire logic clk,
	// Requests from the bench.
	input wire logic [5:0] fire,
	input wire logic torch_req,
	input wire logic strobe_req,
	// Detector and activity lines.
	output logic [5:0] det,
	output logic torch_on,
	output logic strobe_on
);
	// Detectors give single-cycle pulses, the shortest form a real detector may give.
	always_ff @(posedge clk)
	begin
		det <= fire;
		torch_on <= torch_req;
		strobe_on <= strobe_req;
	end
endmodule : sles_far_side

// [tb/tb.sv]
// Self-checking testbench for the strobe event register block.
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_rvalid, boost_use_adaptive, boost_fixed, event_irq, torch_on, strobe_on;
	logic [2:0] boost_mode;
	logic [12:0] boost_target_mv;
	logic [5:0] fire = 6'h00;
	logic [5:0] det;
	logic torch_req = 1'b0;
	logic strobe_req = 1'b0;
	logic [7:0] d;
	logic [6:0] codes [6] = '{7'h00, 7'h0C, 7'h0D, 7'h63, 7'h64, 7'h7F};
	int error_cnt = 0;
	int checked = 0;
	always #2 clk = ~clk;
	sles_far_side i_sles_far_side (.clk(clk), .fire(fire), .torch_req(torch_req),
		.strobe_req(strobe_req), .det(det), .torch_on(torch_on), .strobe_on(strobe_on));
	sles_regs i_sles_regs (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.chan_b_open_evt(det[0]), .chan_b_short_evt(det[1]), .chan_a_open_evt(det[2]),
		.chan_a_short_evt(det[3]), .current_reduction_irq(det[4]),
		.current_not_held_evt(det[5]), .torch_active(torch_on), .strobe_active(strobe_on),
		.boost_mode(boost_mode), .boost_use_adaptive(boost_use_adaptive),
		.boost_fixed(boost_fixed), .boost_target_mv(boost_target_mv), .event_irq(event_irq));
	task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Any detector request is dropped as the read starts, so a pulse can meet the read.
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		fire <= 6'h00;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		cmp(13'(reg_rvalid), 13'h0001);
		d = reg_rdata;
	endtask : rd
	function automatic int mv(input int c);
		return c <= 12 ? 3300 : (c >= 100 ? 5500 : 3300 + 25 * (c - 12));
	endfunction : mv
	task automatic complete_run;
		$display("mismatches %0d, comparisons %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	initial
	begin
		#20000;
		error_cnt++;
		complete_run();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		rd(sles_pkg::SLES_ADDR_EVENTS);
		cmp(13'(d), 13'h0000);
		rd(sles_pkg::SLES_ADDR_MASKS);
		cmp(13'(d), 13'h00FF);
		rd(8'h3C);
		cmp(13'(d), 13'h0000);
		for (int m = 0; m < 2; m++)
		begin
			wr(sles_pkg::SLES_ADDR_MASKS, m ? 8'h00 : 8'hFF);
			for (int i = 0; i < 6; i++)
			begin
				@(posedge clk);
				fire <= 6'h01 << i;
				@(posedge clk);
				fire <= 6'h00;
				repeat (2) @(posedge clk);
				#1;
				cmp(13'(event_irq), 13'((i >= 4) ^ m));
				rd(sles_pkg::SLES_ADDR_EVENTS);
				cmp(13'(d), 13'h0001 << i);
				rd(sles_pkg::SLES_ADDR_EVENTS);
				cmp(13'(d), 13'h0000);
				cmp(13'(event_irq), 13'h0000);
			end
		end
		@(posedge clk);
		fire <= 6'h20;
		rd(sles_pkg::SLES_ADDR_EVENTS);
		cmp(13'(d), 13'h0000);
		rd(sles_pkg::SLES_ADDR_EVENTS);
		cmp(13'(d), 13'h0020);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			torch_req <= k[0];
			strobe_req <= k[1];
			repeat (3) @(posedge clk);
			rd(sles_pkg::SLES_ADDR_ACTIVITY);
			cmp(13'(d), 13'(k * 4));
		end
		wr(sles_pkg::SLES_ADDR_ACTIVITY, 8'hFF);
		rd(sles_pkg::SLES_ADDR_ACTIVITY);
		cmp(13'(d), 13'h000C);
		wr(sles_pkg::SLES_ADDR_EVENTS, 8'hFF);
		rd(sles_pkg::SLES_ADDR_EVENTS);
		cmp(13'(d), 13'h0000);
		wr(sles_pkg::SLES_ADDR_BOOST_MODE, {5'h00, sles_pkg::SLES_MODE_FIXED});
		foreach (codes[j])
		begin
			wr(sles_pkg::SLES_ADDR_BOOST_CODE, {1'b0, codes[j]});
			repeat (2) @(posedge clk);
			#1;
			cmp(boost_target_mv, 13'(mv(int'(codes[j]))));
			rd(sles_pkg::SLES_ADDR_BOOST_CODE);
			cmp(13'(d), 13'(codes[j]));
		end
		for (int m = 0; m < 8; m++)
		begin
			wr(sles_pkg::SLES_ADDR_BOOST_MODE, 8'(m));
			repeat (2) @(posedge clk);
			#1;
			cmp(13'({boost_use_adaptive, boost_fixed}), 13'(m >= 1 && m <= 3 ? 2 : m == 4));
			cmp(boost_target_mv, 13'(m == 4 ? 5500 : 0));
			cmp(13'(boost_mode), 13'(m));
			rd(sles_pkg::SLES_ADDR_BOOST_MODE);
			cmp(13'(d), 13'(m));
		end
		complete_run();
	end
endmodule : tb
